// *** common/option_store_pkg.sv ***
/*
  Constants for the option-byte store: the addresses of every option byte,
  the factory values of true and inverted copies, field positions inside
  the option bytes, the boot decision codes and the loader state encoding.
  Assumes a byte-wide store that sits on a 16-bit address space.
*/
package option_store_pkg;

  // ------------------------------------------------------------------
  // Option byte addresses
  // ------------------------------------------------------------------
  localparam logic [15:0] OPT_BASE = 16'h4800;
  localparam logic [15:0] ADDR_READOUT_PROTECTION = 16'h4800;
  localparam logic [15:0] ADDR_USER_BOOT_AREA_SIZE = 16'h4801;
  localparam logic [15:0] ADDR_USER_BOOT_AREA_SIZE_INV = 16'h4802;
  localparam logic [15:0] ADDR_PIN_FUNCTION_REMAP = 16'h4803;
  localparam logic [15:0] ADDR_PIN_FUNCTION_REMAP_INV = 16'h4804;
  localparam logic [15:0] ADDR_WATCHDOG_OPTIONS = 16'h4805;
  localparam logic [15:0] ADDR_WATCHDOG_OPTIONS_INV = 16'h4806;
  localparam logic [15:0] ADDR_CLOCK_OPTIONS = 16'h4807;
  localparam logic [15:0] ADDR_CLOCK_OPTIONS_INV = 16'h4808;
  localparam logic [15:0] ADDR_CRYSTAL_STARTUP_COUNT = 16'h4809;
  localparam logic [15:0] ADDR_CRYSTAL_STARTUP_COUNT_INV = 16'h480A;
  localparam logic [15:0] ADDR_SPARE_OPTION = 16'h480B;
  localparam logic [15:0] ADDR_SPARE_OPTION_INV = 16'h480C;
  localparam logic [15:0] ADDR_FLASH_WAIT_STATES = 16'h480D;
  localparam logic [15:0] ADDR_FLASH_WAIT_STATES_INV = 16'h480E;
  localparam logic [15:0] ADDR_BOOT_LOADER_SELECT = 16'h487E;
  localparam logic [15:0] ADDR_BOOT_LOADER_SELECT_INV = 16'h487F;

  // ------------------------------------------------------------------
  // Factory values and decision codes
  // ------------------------------------------------------------------
  localparam logic [7:0] RESET_TRUE_COPY = 8'h00;
  localparam logic [7:0] RESET_INVERTED_COPY = 8'hFF;
  localparam logic [7:0] LOADER_ENABLE_CODE = 8'h55;
  localparam logic [7:0] VECTOR_BLANK_CODE = 8'h00;
  localparam logic [7:0] READOUT_OPEN_CODE = 8'h00;

  // ------------------------------------------------------------------
  // Loader walk: slot 0 is the single lock byte, 1..7 pairs, 8 loader
  // ------------------------------------------------------------------
  localparam int SLOT_COUNT = 9;
  localparam logic [3:0] SLOT_LOCK = 4'h0;
  localparam logic [3:0] SLOT_LAST_PAIR = 4'h7;
  localparam logic [3:0] SLOT_LOADER = 4'h8;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int POS_SLOW_RC_ENABLE = 3;
  localparam int POS_INDEPENDENT_DOG_HW_START = 2;
  localparam int POS_WINDOW_DOG_HW_START = 1;
  localparam int POS_WINDOW_DOG_HALT_RESET = 0;
  localparam int POS_EXTERNAL_CLOCK_INPUT = 3;
  localparam int POS_WAKEUP_CLOCK_SELECT = 2;
  localparam int POS_PRESCALE_HI = 1;
  localparam int POS_FLASH_WAIT_OPTION = 0;
  localparam int POS_PIN_REMAP_BIT7 = 7;

  // Loader states, Gray coded along the walk
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_DECIDE = 2'b01,
    ST_DONE = 2'b11
  } load_state_t;

endpackage

// *** rtl/option_byte_store.sv ***
/*
  Option-byte store: a dedicated byte array holding the option bytes,
  written by the debug-port programmer or by the running application,
  and a loader that, after each reset, checks every true/inverted pair,
  presents the settings and decides the start path.
  Assumes the debug-port logic, the CPU and the program flash all run on
  clk; their strobes are one-cycle pulses on that clock.
*/
// How it works
// - Options live in their own dedicated array
// - Each option except lock stored true and inverted
// - Application rewrites options at run time
// - Lock byte writable only from debug port
// - After reset, choose loader or reset vector
// - Loader code byte, complement at next address
`timescale 1ns/10ps
module option_byte_store (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Debug-port programmer write strobe
  input wire logic icp_wr,
  input wire logic [15:0] icp_addr,
  input wire logic [7:0] icp_wdata,
  // Application write strobe
  input wire logic iap_wr,
  input wire logic [15:0] iap_addr,
  input wire logic [7:0] iap_wdata,
  output logic iap_refused,
  // Read port, one cycle latency
  input wire logic rd_en,
  input wire logic [15:0] rd_addr,
  output logic [7:0] rd_data,
  // Loader control and boot inputs
  input wire logic reload,
  input wire logic [7:0] reset_vector_byte,
  // Loaded settings
  output logic [7:0] readout_lock_code,
  output logic readout_lock,
  output logic [7:0] user_boot_area_size_field,
  output logic [7:0] pin_function_remap,
  output logic pin_remap_bit7,
  output logic slow_rc_enable,
  output logic independent_dog_hw_start,
  output logic window_dog_hw_start,
  output logic window_dog_halt_reset,
  output logic external_clock_input,
  output logic wakeup_clock_select,
  output logic [1:0] clock_prescale,
  output logic [7:0] crystal_settle_cycles,
  output logic flash_wait_option,
  output logic [7:0] loader_enable_code,
  // Boot decision and health
  output logic [8:0] option_error,
  output logic boot_done,
  output logic boot_to_loader
);

  // ------------------------------------------------------------------
  // Address decoding helpers
  // ------------------------------------------------------------------

  // Position of an address inside the 128-byte option block
  function automatic logic [6:0] store_index(input logic [15:0] a);
    store_index = a[6:0];
  endfunction

  // Address falls on a defined option byte
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a[15:7] == option_store_pkg::OPT_BASE[15:7]) &&
      ((a <= option_store_pkg::ADDR_FLASH_WAIT_STATES_INV) ||
       (a >= option_store_pkg::ADDR_BOOT_LOADER_SELECT));
  endfunction

  // Address is the spare pair, which ignores writes
  function automatic logic is_spare(input logic [15:0] a);
    is_spare = (a == option_store_pkg::ADDR_SPARE_OPTION) ||
      (a == option_store_pkg::ADDR_SPARE_OPTION_INV);
  endfunction

  // Array position of the true copy for a loader slot
  function automatic logic [6:0] slot_index(input logic [3:0] s);
    logic [6:0] odd;
    odd = {2'b00, s, 1'b0} - 7'h01;
    if (s == option_store_pkg::SLOT_LOCK) begin
      slot_index = store_index(option_store_pkg::ADDR_READOUT_PROTECTION);
    end else if (s == option_store_pkg::SLOT_LOADER) begin
      slot_index = store_index(option_store_pkg::ADDR_BOOT_LOADER_SELECT);
    end else begin
      slot_index = odd;
    end
  endfunction

  // ------------------------------------------------------------------
  // Option array
  // ------------------------------------------------------------------
  logic [7:0] store_mem [0:127]; // Non-volatile option block image

  // ------------------------------------------------------------------
  // Write arbitration
  // ------------------------------------------------------------------
  wire icp_ok; // Programmer write lands
  wire iap_hits_lock; // Application aims at the lock byte
  wire iap_ok; // Application write lands
  wire mem_we; // Array write strobe
  wire [6:0] mem_idx; // Array write position
  wire [7:0] mem_wdata; // Array write byte

  // Programmer may write every defined byte except the spare pair, the lock byte included
  assign icp_ok = icp_wr && is_mapped(icp_addr) && !is_spare(icp_addr);
  // The lock byte is out of reach for the application
  assign iap_hits_lock =
    (iap_addr == option_store_pkg::ADDR_READOUT_PROTECTION);
  // Application writes yield to a programmer write in the same cycle
  assign iap_ok = iap_wr && !icp_wr && is_mapped(iap_addr) &&
    !is_spare(iap_addr) && !iap_hits_lock;
  assign mem_we = icp_ok || iap_ok;
  assign mem_idx = icp_ok ? store_index(icp_addr) : store_index(iap_addr);
  assign mem_wdata = icp_ok ? icp_wdata : iap_wdata;

  // Array update; stored bytes survive reset like flash cells
  always_ff @(posedge clk) begin
    if (mem_we) begin
      store_mem[mem_idx] <= mem_wdata;
    end
  end

  // Refusal pulse for an application write aimed at the lock byte
  logic iap_refused_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iap_refused_q <= 1'b0;
    end else begin
      iap_refused_q <= iap_wr && iap_hits_lock;
    end
  end
  assign iap_refused = iap_refused_q;

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  logic [7:0] rd_data_q;
  wire [7:0] rd_pick; // Byte at the read address, zero when unmapped
  assign rd_pick = is_mapped(rd_addr) ?
    store_mem[store_index(rd_addr)] : 8'h00;

  // Latch the byte one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
    end else if (rd_en) begin
      rd_data_q <= rd_pick;
    end
  end
  assign rd_data = rd_data_q;

  // ------------------------------------------------------------------
  // Loader walk
  // ------------------------------------------------------------------
  option_store_pkg::load_state_t state_q;
  logic [3:0] slot_q; // Slot being checked
  logic [7:0] loaded_q [0:8]; // Accepted setting per slot
  logic [8:0] err_q; // Corrupted pair per slot
  logic boot_done_q;
  logic boot_to_loader_q;

  wire [7:0] true_byte; // True copy of the current slot
  wire [7:0] inv_byte; // Inverted copy at the next address
  wire pair_ok; // Copies are exact complements
  wire slot_is_pair; // Slot carries a complement
  wire loader_wanted; // Loader code valid and enabled
  wire vector_blank; // No application at the reset vector

  assign true_byte = store_mem[slot_index(slot_q)];
  assign inv_byte = store_mem[slot_index(slot_q) + 7'h01];
  assign pair_ok = (true_byte == ~inv_byte);
  assign slot_is_pair = (slot_q != option_store_pkg::SLOT_LOCK);
  assign loader_wanted = !err_q[option_store_pkg::SLOT_LOADER] &&
    (loaded_q[option_store_pkg::SLOT_LOADER] ==
     option_store_pkg::LOADER_ENABLE_CODE);
  assign vector_blank =
    (reset_vector_byte == option_store_pkg::VECTOR_BLANK_CODE);

  // Walk state, slot counter and boot decision
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= option_store_pkg::ST_LOAD;
      slot_q <= 4'h0;
      boot_done_q <= 1'b0;
      boot_to_loader_q <= 1'b0;
    end else begin
      case (state_q)
        option_store_pkg::ST_LOAD: begin
          // Step through the slots, lock byte first
          if (slot_q == option_store_pkg::SLOT_LOADER) begin
            state_q <= option_store_pkg::ST_DECIDE;
          end else begin
            slot_q <= slot_q + 4'h1;
          end
        end
        option_store_pkg::ST_DECIDE: begin
          // Loader when asked for or when no application exists
          boot_to_loader_q <= loader_wanted || vector_blank;
          boot_done_q <= 1'b1;
          state_q <= option_store_pkg::ST_DONE;
        end
        option_store_pkg::ST_DONE: begin
          // A reload request runs the walk again
          if (reload) begin
            state_q <= option_store_pkg::ST_LOAD;
            slot_q <= 4'h0;
            boot_done_q <= 1'b0;
          end
        end
        default: begin
          state_q <= option_store_pkg::ST_LOAD;
          slot_q <= 4'h0;
        end
      endcase
    end
  end

  // Accepted settings, factory value when a pair is corrupted
  genvar gs;
  generate
    for (gs = 0; gs < option_store_pkg::SLOT_COUNT; gs++) begin : g_slot
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          loaded_q[gs] <= option_store_pkg::RESET_TRUE_COPY;
          err_q[gs] <= 1'b0;
        end else if (state_q == option_store_pkg::ST_LOAD &&
                     slot_q == 4'(gs)) begin
          if (!slot_is_pair || pair_ok) begin
            loaded_q[gs] <= true_byte;
            err_q[gs] <= 1'b0;
          end else begin
            loaded_q[gs] <= option_store_pkg::RESET_TRUE_COPY;
            err_q[gs] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Setting outputs
  // ------------------------------------------------------------------
  assign readout_lock_code = loaded_q[0];
  assign readout_lock = (loaded_q[0] != option_store_pkg::READOUT_OPEN_CODE);
  assign user_boot_area_size_field = loaded_q[1];
  assign pin_function_remap = loaded_q[2];
  assign pin_remap_bit7 = loaded_q[2][option_store_pkg::POS_PIN_REMAP_BIT7];
  assign slow_rc_enable = loaded_q[3][option_store_pkg::POS_SLOW_RC_ENABLE];
  assign independent_dog_hw_start =
    loaded_q[3][option_store_pkg::POS_INDEPENDENT_DOG_HW_START];
  assign window_dog_hw_start =
    loaded_q[3][option_store_pkg::POS_WINDOW_DOG_HW_START];
  assign window_dog_halt_reset =
    loaded_q[3][option_store_pkg::POS_WINDOW_DOG_HALT_RESET];
  assign external_clock_input =
    loaded_q[4][option_store_pkg::POS_EXTERNAL_CLOCK_INPUT];
  assign wakeup_clock_select =
    loaded_q[4][option_store_pkg::POS_WAKEUP_CLOCK_SELECT];
  assign clock_prescale = loaded_q[4][option_store_pkg::POS_PRESCALE_HI:0];
  assign crystal_settle_cycles = loaded_q[5];
  // Software keeps this set before raising the core clock to the top rate
  assign flash_wait_option =
    loaded_q[7][option_store_pkg::POS_FLASH_WAIT_OPTION];
  assign loader_enable_code = loaded_q[8];
  assign option_error = err_q;
  assign boot_done = boot_done_q;
  assign boot_to_loader = boot_to_loader_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_lock_iap_blocked: assert property (
    @(posedge clk) disable iff (!rst_n)
    iap_wr && !icp_wr && iap_hits_lock |=>
      store_mem[0] == $past(store_mem[0]) && iap_refused)
    else $error("application write changed the lock byte");

  a_lock_icp_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    icp_wr && icp_addr == option_store_pkg::ADDR_READOUT_PROTECTION |=>
      store_mem[0] == $past(icp_wdata))
    else $error("programmer write to lock byte lost");

  a_iap_write_lands: assert property (
    @(posedge clk) disable iff (!rst_n)
    iap_wr && !icp_wr &&
    iap_addr == option_store_pkg::ADDR_USER_BOOT_AREA_SIZE |=>
      store_mem[1] == $past(iap_wdata) && !iap_refused)
    else $error("application write did not land");

  a_spare_untouched: assert property (
    @(posedge clk) disable iff (!rst_n)
    icp_wr && is_spare(icp_addr) |->
      !mem_we)
    else $error("spare option byte was written");

  a_pair_corrupt_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_q == option_store_pkg::ST_LOAD && slot_is_pair && !pair_ok |=>
      err_q[$past(slot_q)] &&
      loaded_q[$past(slot_q)] == option_store_pkg::RESET_TRUE_COPY)
    else $error("corrupted pair not flagged");

  a_pair_good_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_q == option_store_pkg::ST_LOAD && pair_ok |=>
      !err_q[$past(slot_q)] && loaded_q[$past(slot_q)] == $past(true_byte))
    else $error("valid pair not taken");

  a_loader_complement: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_q == option_store_pkg::ST_LOAD &&
    slot_q == option_store_pkg::SLOT_LOADER |->
      slot_index(slot_q) + 7'h01 ==
      store_index(option_store_pkg::ADDR_BOOT_LOADER_SELECT_INV))
    else $error("loader complement read from wrong place");

  a_boot_walk_time: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_q == option_store_pkg::ST_LOAD && slot_q == 4'h0 |->
      !boot_done ##10 boot_done)
    else $error("boot decision not made in ten cycles");

  a_boot_path_choice: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(boot_done) |->
      boot_to_loader == ($past(loader_wanted) || $past(vector_blank)))
    else $error("wrong start path chosen");

endmodule

// *** verification/icp_programmer.sv ***
/*
  Model of the external programmer on the debug port: it writes single
  option bytes and true/complement pairs into the store.
  Assumes it shares clk with the store and is driven by the bench tasks.
*/
`timescale 1ns/10ps
module icp_programmer (
  // Clock
  input wire logic clk,
  // Programmer write strobe toward the store
  output logic icp_wr,
  output logic [15:0] icp_addr,
  output logic [7:0] icp_wdata
);
  // ------------------------------------------------------------------
  // Write driver
  // ------------------------------------------------------------------
  // Idle at time zero
  initial begin
    icp_wr = 1'b0;
    icp_addr = 16'h0000;
    icp_wdata = 8'h00;
  end
  // One byte with a one-cycle strobe, launched just after an edge
  task automatic put_byte(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    icp_wr = 1'b1;
    icp_addr = a;
    icp_wdata = d;
    @(posedge clk);
    #1;
    icp_wr = 1'b0;
    // Released lines stop showing the last value
    icp_addr = ~icp_addr;
    icp_wdata = ~icp_wdata;
  endtask
  // True copy, then its complement one address up
  task automatic put_pair(input logic [15:0] a, input logic [7:0] d);
    put_byte(a, d);
    put_byte(a + 16'h0001, ~d);
  endtask
endmodule

// *** verification/option_byte_store_tb.sv ***
/*
  Self-checking bench for the option-byte store: programs it through the
  programmer model, rewrites it from the application side and checks the
  read port, the loaded settings and the boot decision.
  Assumes the store and the programmer model are compiled before it.
*/
`timescale 1ns/10ps
module option_byte_store_tb;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clk, rst_n, iap_wr, rd_en, reload, iap_refused, icp_wr;
  logic [15:0] iap_addr, rd_addr, icp_addr;
  logic [7:0] iap_wdata, reset_vector_byte, rd_data, icp_wdata;
  logic [7:0] readout_lock_code, user_boot_area_size_field;
  logic [7:0] pin_function_remap, crystal_settle_cycles, loader_enable_code;
  logic readout_lock, pin_remap_bit7, slow_rc_enable, window_dog_hw_start;
  logic independent_dog_hw_start, window_dog_halt_reset, boot_done;
  logic external_clock_input, wakeup_clock_select, flash_wait_option;
  logic boot_to_loader;
  logic [1:0] clock_prescale;
  logic [8:0] option_error;
  logic refused; // Refusal flag seen after an application write
  int mismatches, checks_done; // Mismatch and comparison counters

  // ------------------------------------------------------------------
  // Store and programmer
  // ------------------------------------------------------------------
  option_byte_store u_dut (.clk, .rst_n, .icp_wr, .icp_addr, .icp_wdata,
    .iap_wr, .iap_addr, .iap_wdata, .iap_refused, .rd_en, .rd_addr, .rd_data,
    .reload, .reset_vector_byte, .readout_lock_code, .readout_lock,
    .user_boot_area_size_field, .pin_function_remap, .pin_remap_bit7,
    .slow_rc_enable, .independent_dog_hw_start, .window_dog_hw_start,
    .window_dog_halt_reset, .external_clock_input, .wakeup_clock_select,
    .clock_prescale, .crystal_settle_cycles, .flash_wait_option,
    .loader_enable_code, .option_error, .boot_done, .boot_to_loader);
  icp_programmer u_prog (.clk, .icp_wr, .icp_addr, .icp_wdata);

  // 40 MHz core clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Compares one byte, four-state exact
  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Application write; returns the refusal flag of the next cycle
  task automatic app_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    iap_wr = 1'b1;
    iap_addr = a;
    iap_wdata = d;
    @(posedge clk);
    #1;
    iap_wr = 1'b0;
    iap_addr = ~iap_addr;
    iap_wdata = ~iap_wdata;
    refused = iap_refused;
  endtask
  // Read with one cycle latency, then compare
  task automatic read_chk(input string what, input logic [15:0] a,
                          input logic [7:0] exp);
    @(posedge clk);
    #1;
    rd_en = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    rd_addr = ~rd_addr;
    check8(what, exp, rd_data);
  endtask
  // Bounded wait for the end of the loader walk
  task automatic boot_wait();
    for (int i = 0; i < 40; i++) begin
      if (boot_done === 1'b1) return;
      @(posedge clk);
      #1;
    end
    mismatches++;
    $display("FAIL boot_done expected 1 seen %b", boot_done);
    wrap_up();
  endtask
  // Restart the walk and wait for the new decision
  task automatic do_reload();
    @(posedge clk);
    #1;
    reload = 1'b1;
    @(posedge clk);
    #1;
    reload = 1'b0;
    @(posedge clk);
    #1;
    boot_wait();
  endtask

  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    $display("FAIL run_time expected end seen hang");
    wrap_up();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {iap_wr, rd_en, reload} = 3'b000;
    {iap_addr, rd_addr} = 32'h0000_0000;
    iap_wdata = 8'h00;
    reset_vector_byte = 8'h80;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    boot_wait();
    // Programmer fills every option byte except the spare pair
    u_prog.put_byte(16'h4800, 8'hA5);
    u_prog.put_pair(16'h4801, 8'h12);
    u_prog.put_pair(16'h4803, 8'h80);
    u_prog.put_pair(16'h4805, 8'h0A);
    u_prog.put_pair(16'h4807, 8'h06);
    u_prog.put_pair(16'h4809, 8'h3C);
    u_prog.put_pair(16'h480D, 8'h01);
    // Spare byte ignores programmer writes
    u_prog.put_byte(16'h480B, 8'h5A);
    u_prog.put_pair(16'h487E, option_store_pkg::LOADER_ENABLE_CODE);
    read_chk("lock_byte", 16'h4800, 8'hA5);
    read_chk("boot_area_inv", 16'h4802, 8'hED);
    read_chk("loader_inv", 16'h487F, 8'hAA);
    read_chk("unmapped", 16'h4810, 8'h00);
    do_reload();
    check8("lock_code", 8'hA5, readout_lock_code);
    check8("lock", 8'h01, {7'h00, readout_lock});
    check8("boot_area", 8'h12, user_boot_area_size_field);
    check8("remap", 8'h80, pin_function_remap);
    check8("remap7", 8'h01, {7'h00, pin_remap_bit7});
    check8("dog_bits", 8'h0A, {4'h0, slow_rc_enable, independent_dog_hw_start,
      window_dog_hw_start, window_dog_halt_reset});
    check8("clk_bits", 8'h06, {4'h0, external_clock_input,
      wakeup_clock_select, clock_prescale});
    check8("settle", 8'h3C, crystal_settle_cycles);
    check8("wait_opt", 8'h01, {7'h00, flash_wait_option});
    check8("loader_code", 8'h55, loader_enable_code);
    check8("errors", 8'h00, {option_error[8:7], option_error[5:0]});
    check8("to_loader", 8'h01, {7'h00, boot_to_loader});
    // Application side: lock refused, ordinary pair accepted
    app_write(16'h4800, 8'h00);
    check8("refused_lock", 8'h01, {7'h00, refused});
    read_chk("lock_kept", 16'h4800, 8'hA5);
    app_write(16'h480D, 8'h00);
    check8("refused_wait", 8'h00, {7'h00, refused});
    app_write(16'h480E, 8'hFF);
    read_chk("wait_rewrite", 16'h480D, 8'h00);
    // Broken pairs: settle count and loader code
    app_write(16'h480A, 8'h00);
    app_write(16'h487F, 8'h00);
    // Application rewrites the boot area pair with a new value
    app_write(16'h4801, 8'h34);
    app_write(16'h4802, 8'hCB);
    do_reload();
    check8("area_rewrite", 8'h34, user_boot_area_size_field);
    check8("settle_bad", 8'h00, crystal_settle_cycles);
    check8("wait_off", 8'h00, {7'h00, flash_wait_option});
    check8("loader_bad", 8'h00, loader_enable_code);
    check8("errors_bad", 8'hA0, {option_error[8:7], option_error[5:0]});
    check8("to_vector", 8'h00, {7'h00, boot_to_loader});
    // Blank reset vector sends the core to the loader
    reset_vector_byte = 8'h00;
    do_reload();
    check8("blank_vector", 8'h01, {7'h00, boot_to_loader});
    // Reset in mid-run: outputs clear, store contents survive
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    check8("rst_done", 8'h00, {7'h00, boot_done});
    check8("rst_lock", 8'h00, readout_lock_code);
    rst_n = 1'b1;
    @(posedge clk);
    #1;
    boot_wait();
    check8("kept_lock", 8'hA5, readout_lock_code);
    check8("kept_area", 8'h34, user_boot_area_size_field);
    wrap_up();
  end
endmodule
